/* src/cir_pkg.sv */
// Package: constants and types of the checksum integrity supervisor
package cir_pkg;
	// Recovery options word bit positions
	localparam int CIR_OPT_APP_ON_FATAL = 0;
	localparam int CIR_OPT_APP_ALWAYS = 1;
	localparam int CIR_OPT_CFG_ON_CKS = 2;
	localparam int CIR_OPT_CFG_ON_FATAL = 3;
	localparam int CIR_OPT_CFG_ALWAYS = 4;
	localparam int CIR_OPT_COMM_ON_CKS = 5;
	localparam int CIR_OPT_COMM_ON_MISM = 6;
	localparam int CIR_OPT_COMM_ALWAYS = 7;
	localparam int CIR_OPT_VARS_WITH_APP = 8;
	localparam int CIR_OPT_NOAPP_FATAL = 9;
	localparam int CIR_OPT_ALL_CODE = 10;
	// Area selectors
	localparam logic [1:0] CIR_AREA_CFG = 2'h0;
	localparam logic [1:0] CIR_AREA_APP = 2'h1;
	localparam logic [1:0] CIR_AREA_SYS = 2'h2;
	// Error log codes
	localparam logic [7:0] CIR_ERR_CFG_CKS = 8'h01;
	localparam logic [7:0] CIR_ERR_APP_CKS = 8'h02;
	localparam logic [7:0] CIR_ERR_SYS_CKS = 8'h03;
	localparam logic [7:0] CIR_ERR_RECOVERY = 8'h04;
	// Device state codes
	localparam logic [1:0] CIR_DEV_CONFIGURED = 2'h0;
	localparam logic [1:0] CIR_DEV_UNCONFIGURED = 2'h1;
	localparam logic [1:0] CIR_DEV_NOAPP = 2'h2;
	// Reset values
	localparam logic [1:0] CIR_DEV_RESET = 2'h0;
	localparam logic [15:0] CIR_OPT_RESET = 16'h0000;
	// Background pacing: one byte per main loop, about 3 per ms
	localparam int CIR_CLK_MHZ = 250;
	localparam int CIR_BG_BYTES_PER_MS = 3;
	localparam int CIR_BG_GAP_CYC = (CIR_CLK_MHZ * 1000) / CIR_BG_BYTES_PER_MS;
	// Attempts before a reset-time check is judged bad
	localparam int CIR_EXT_TRIES = 2;
	// Sequencer states
	typedef enum logic [3:0] {
		CIR_IDLE, CIR_RD, CIR_WAIT, CIR_JUDGE, CIR_COPY, CIR_LOG,
		CIR_DONE, CIR_BG
	} cir_state_e;
endpackage

/* src/cir_top.sv */
// Module: checksum integrity and recovery supervisor
`timescale 1ns/1ps
//
// Contract
// - Checksum byte is negated sum of area
// - Verify at reset and in background
// - Config failure makes device unconfigured by default
// - Application failure makes device applicationless by default
// - Code areas split over three checksums
// - Background adds one byte per loop step
// - No checking while applicationless
// - System image failure forces applicationless
// - Background failure requests reset, no state change
// - Reset check sets state and logs error
// - External variant needs two failed attempts
// - Sixteen-bit options word steers recovery
// - Recovery recopies chosen areas from boot image
// - Bits 0 and 1 reload application
// - Bits 2, 3, 4 reload configuration
// - Bits 5, 6, 7 reload communication parameters
// - Bit 8 adds variables to application reload
// - Bit 9 treats applicationless as fatal
// - Bit 10 extends coverage to system image
// - Alloc and map failures are fatal too
// - Config reloads alone only if sizes match
// - Every recovery logs a recovery entry
// - Config checked before application
module cir_top import cir_pkg::*; #(
	parameter int ADDR_W = 16,
	parameter bit EXT_MEM = 1'b1,
	parameter int BG_GAP = CIR_BG_GAP_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rst_start,
	input wire logic [15:0] boot_options,
	input wire logic sys_offchip,
	input wire logic [ADDR_W-1:0] cfg_base,
	input wire logic [ADDR_W-1:0] cfg_len,
	input wire logic [ADDR_W-1:0] app_base,
	input wire logic [ADDR_W-1:0] app_len,
	input wire logic [ADDR_W-1:0] sys_base,
	input wire logic [ADDR_W-1:0] sys_len,
	input wire logic [1:0] dev_state_in,
	input wire logic alloc_fail,
	input wire logic map_fail,
	input wire logic comm_mismatch,
	input wire logic cfg_sizes_match,
	output logic mem_rd,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_rvalid,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] cfg_cks,
	input wire logic [7:0] app_cks,
	input wire logic [7:0] sys_cks,
	output logic copy_req,
	output logic copy_app,
	output logic copy_cfg,
	output logic copy_comm,
	output logic copy_vars,
	input wire logic copy_done,
	output logic state_we,
	output logic [1:0] state_out,
	output logic log_we,
	output logic [7:0] log_code,
	output logic reset_req,
	output logic busy
);
	initial begin
		if (ADDR_W < 4 || ADDR_W > 32) $error("ADDR_W out of range");
		if (BG_GAP < 1) $error("BG_GAP must be positive");
	end

	// Width-safe gap count
	localparam logic [31:0] GAP_M1 = 32'(BG_GAP - 1);

	// Checksum test: sum plus stored byte must be zero
	function automatic logic cks_ok(input logic [7:0] s, input logic [7:0] c);
		cks_ok = ((s + c) == 8'h00);
	endfunction

	cir_state_e st_r; // Sequencer state
	logic [1:0] area_r; // Area now being summed
	logic [ADDR_W-1:0] idx_r; // Byte index inside area
	logic [7:0] sum_r; // Running byte sum
	logic try_r; // Second attempt in progress
	logic bg_r; // Pass belongs to background
	logic [31:0] gap_r; // Background pacing counter
	logic [15:0] opt_r; // Latched options word
	logic [1:0] dev_r; // Device state as decided
	logic [2:0] pend_r; // Failed areas: bit 0 cfg, 1 app, 2 sys
	logic fatal_r; // Application fatal seen this pass

	logic [ADDR_W-1:0] base_w;
	logic [ADDR_W-1:0] len_w;
	logic [7:0] ref_w;
	logic last_w;
	logic good_w;
	logic fat_w; // Application fatal, option bit 9 included
	logic app_w; // Application reload wanted
	logic cfg_w; // Configuration reload wanted
	logic comm_w; // Communication parameter reload wanted

	// Area selection, system image included only when present
	always_comb begin
		case (area_r)
			CIR_AREA_CFG: begin
				base_w = cfg_base;
				len_w = cfg_len;
				ref_w = cfg_cks;
			end
			CIR_AREA_APP: begin
				base_w = app_base;
				len_w = app_len;
				ref_w = app_cks;
			end
			default: begin
				base_w = sys_base;
				len_w = sys_len;
				ref_w = sys_cks;
			end
		endcase
		last_w = (idx_r + 1'b1) >= len_w;
		good_w = cks_ok(sum_r, ref_w);
	end

	// System area exists when off-chip or full coverage asked
	logic sys_on_w;
	assign sys_on_w = sys_offchip | opt_r[CIR_OPT_ALL_CODE];

	// Recovery decision, taken by the copy step once all areas are judged
	always_comb begin
		fat_w = fatal_r | (opt_r[CIR_OPT_NOAPP_FATAL] &&
			dev_r == CIR_DEV_NOAPP && !pend_r[2]);
		app_w = (fat_w & opt_r[CIR_OPT_APP_ON_FATAL]) |
			opt_r[CIR_OPT_APP_ALWAYS];
		// Config alone needs matching table sizes, else code is corrupted
		cfg_w = ((pend_r[0] & opt_r[CIR_OPT_CFG_ON_CKS]) |
			(fat_w & opt_r[CIR_OPT_CFG_ON_FATAL]) |
			opt_r[CIR_OPT_CFG_ALWAYS]) & (app_w | cfg_sizes_match);
		comm_w = (pend_r[0] & opt_r[CIR_OPT_COMM_ON_CKS]) |
			(comm_mismatch & opt_r[CIR_OPT_COMM_ON_MISM]) |
			opt_r[CIR_OPT_COMM_ALWAYS];
	end

	// Main sequencer: reset pass then background passes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= CIR_IDLE;
			area_r <= CIR_AREA_CFG;
			idx_r <= '0;
			sum_r <= 8'h00;
			try_r <= 1'b0;
			bg_r <= 1'b0;
			gap_r <= '0;
			opt_r <= CIR_OPT_RESET;
			dev_r <= CIR_DEV_RESET;
			pend_r <= 3'h0;
			fatal_r <= 1'b0;
			mem_rd <= 1'b0;
			mem_addr <= '0;
			copy_req <= 1'b0;
			copy_app <= 1'b0;
			copy_cfg <= 1'b0;
			copy_comm <= 1'b0;
			copy_vars <= 1'b0;
			state_we <= 1'b0;
			state_out <= CIR_DEV_RESET;
			log_we <= 1'b0;
			log_code <= 8'h00;
			reset_req <= 1'b0;
			busy <= 1'b0;
		end else begin
			mem_rd <= 1'b0;
			state_we <= 1'b0;
			log_we <= 1'b0;
			reset_req <= 1'b0;
			case (st_r)
				CIR_IDLE: begin
					// Nothing runs before the first reset pass
					st_r <= CIR_IDLE;
				end
				CIR_BG: begin
					// Background idles while applicationless
					if (dev_r == CIR_DEV_NOAPP) begin
						gap_r <= '0;
					end else if (gap_r >= GAP_M1) begin
						gap_r <= '0;
						bg_r <= 1'b1;
						st_r <= CIR_RD;
					end else begin
						gap_r <= gap_r + 32'h1;
					end
				end
				CIR_RD: begin
					if (len_w == '0) begin
						st_r <= CIR_JUDGE;
					end else begin
						mem_rd <= 1'b1;
						mem_addr <= base_w + idx_r;
						st_r <= CIR_WAIT;
					end
				end
				CIR_WAIT: begin
					if (mem_rvalid) begin
						sum_r <= sum_r + mem_rdata;
						if (last_w) begin
							st_r <= CIR_JUDGE;
						end else begin
							idx_r <= idx_r + 1'b1;
							// Background paces one byte per gap
							st_r <= bg_r ? CIR_BG : CIR_RD;
						end
					end
				end
				CIR_JUDGE: begin
					idx_r <= '0;
					sum_r <= 8'h00;
					if (bg_r) begin
						// Mismatch only asks for a reset
						if (!good_w) begin
							reset_req <= 1'b1;
						end
						if (area_r == CIR_AREA_CFG) begin
							area_r <= CIR_AREA_APP;
						end else if (area_r == CIR_AREA_APP && sys_on_w) begin
							area_r <= CIR_AREA_SYS;
						end else begin
							area_r <= CIR_AREA_CFG;
						end
						st_r <= CIR_BG;
					end else if (!good_w && EXT_MEM && !try_r) begin
						// Retry once before judging bad
						try_r <= 1'b1;
						st_r <= CIR_RD;
					end else begin
						try_r <= 1'b0;
						st_r <= CIR_RD;
						case (area_r)
							CIR_AREA_CFG: begin
								if (!good_w) begin
									// Outcome settled in the copy step
									pend_r[0] <= 1'b1;
								end
								area_r <= CIR_AREA_APP;
							end
							CIR_AREA_APP: begin
								if (!good_w) begin
									fatal_r <= 1'b1;
									pend_r[1] <= 1'b1;
								end
								if (sys_on_w) begin
									area_r <= CIR_AREA_SYS;
								end else begin
									st_r <= CIR_COPY;
								end
							end
							default: begin
								if (!good_w) begin
									dev_r <= CIR_DEV_NOAPP;
									pend_r[2] <= 1'b1;
								end
								st_r <= CIR_COPY;
							end
						endcase
					end
				end
				CIR_COPY: begin
					// Publish the reloads the options ask for
					copy_app <= app_w;
					copy_cfg <= cfg_w;
					copy_comm <= comm_w;
					copy_vars <= app_w & opt_r[CIR_OPT_VARS_WITH_APP];
					// Applicationless causes win over any later choice
					if (pend_r[2]) begin
						dev_r <= CIR_DEV_NOAPP;
					end else if (pend_r[1] && !app_w) begin
						dev_r <= CIR_DEV_NOAPP;
					end else if (app_w && dev_r == CIR_DEV_NOAPP) begin
						// A reloaded application lifts applicationless state
						dev_r <= cfg_w ? CIR_DEV_CONFIGURED :
							CIR_DEV_UNCONFIGURED;
					end else if (pend_r[0] && !cfg_w &&
						!opt_r[CIR_OPT_COMM_ON_CKS] &&
						dev_r != CIR_DEV_NOAPP) begin
						dev_r <= CIR_DEV_UNCONFIGURED;
					end
					if (app_w | cfg_w | comm_w) begin
						copy_req <= 1'b1;
					end
					st_r <= CIR_LOG;
				end
				CIR_LOG: begin
					// Hold the copy request until the copier answers
					if (!copy_req || copy_done) begin
						copy_req <= 1'b0;
						log_we <= (pend_r != 3'h0) || copy_req;
						if (copy_req) begin
							log_code <= CIR_ERR_RECOVERY;
						end else begin
							// Last failing area gives the code
							if (pend_r[2]) begin
								log_code <= CIR_ERR_SYS_CKS;
							end else if (pend_r[1]) begin
								log_code <= CIR_ERR_APP_CKS;
							end else begin
								log_code <= CIR_ERR_CFG_CKS;
							end
						end
						st_r <= CIR_DONE;
					end
				end
				CIR_DONE: begin
					// Publish the decided state
					state_we <= 1'b1;
					state_out <= dev_r;
					pend_r <= 3'h0;
					fatal_r <= 1'b0;
					copy_app <= 1'b0;
					copy_cfg <= 1'b0;
					copy_comm <= 1'b0;
					copy_vars <= 1'b0;
					busy <= 1'b0;
					area_r <= CIR_AREA_CFG;
					gap_r <= '0;
					st_r <= CIR_BG;
				end
				default: st_r <= CIR_IDLE;
			endcase
			// A reset pass may start whenever none runs, even amid a
			// background byte; that byte is dropped, so the memory must
			// not answer a dropped read after the pass has begun
			if (rst_start && !busy) begin
				// Options sampled once per reset pass
				opt_r <= boot_options;
				dev_r <= dev_state_in;
				area_r <= CIR_AREA_CFG;
				idx_r <= '0;
				sum_r <= 8'h00;
				try_r <= 1'b0;
				bg_r <= 1'b0;
				fatal_r <= alloc_fail | map_fail;
				mem_rd <= 1'b0;
				// The pass rechecks everything, so a pending request is moot
				reset_req <= 1'b0;
				busy <= 1'b1;
				st_r <= CIR_RD;
			end
		end
	end
endmodule // cir_top

/* dv/cir_top_sva.sv */
// Checker: port timing assertions of the integrity supervisor
`timescale 1ns/1ps
module cir_top_sva import cir_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rst_start,
	input wire logic mem_rd,
	input wire logic copy_req,
	input wire logic copy_done,
	input wire logic copy_app,
	input wire logic copy_cfg,
	input wire logic copy_comm,
	input wire logic copy_vars,
	input wire logic state_we,
	input wire logic [1:0] state_out,
	input wire logic log_we,
	input wire logic [7:0] log_code,
	input wire logic reset_req,
	input wire logic busy
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// No memory traffic for a stretch of cycles
	sequence s_quiet; !mem_rd [*8]; endsequence
	property p_rd_pulse; mem_rd |=> !mem_rd; endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read strobe held too long");
	property p_we_pulse; state_we |=> !state_we; endproperty
	a_we_pulse: assert property (p_we_pulse)
		else $error("state write held too long");
	property p_log_pulse; log_we |=> !log_we; endproperty
	a_log_pulse: assert property (p_log_pulse)
		else $error("log write held too long");
	property p_bg_rst; reset_req |-> !state_we && !busy ##1 !reset_req;
	endproperty
	a_bg_rst: assert property (p_bg_rst)
		else $error("background reset request malformed");
	property p_noapp; state_we && state_out == CIR_DEV_NOAPP |=> s_quiet;
	endproperty
	a_noapp: assert property (p_noapp)
		else $error("memory read while applicationless");
	property p_copy_hold; copy_req && !copy_done |=> copy_req; endproperty
	a_copy_hold: assert property (p_copy_hold)
		else $error("copy request dropped early");
	property p_copy_sel;
		copy_req |-> copy_app || copy_cfg || copy_comm || copy_vars;
	endproperty
	a_copy_sel: assert property (p_copy_sel)
		else $error("copy request with no area");
	property p_start; rst_start && !busy |=> busy; endproperty
	a_start: assert property (p_start)
		else $error("reset pass not started");
	property p_log_code;
		log_we |-> log_code != 8'h00 && log_code <= CIR_ERR_RECOVERY;
	endproperty
	a_log_code: assert property (p_log_code)
		else $error("log code out of range");
	property p_vars; copy_vars |-> copy_app; endproperty
	a_vars: assert property (p_vars)
		else $error("variables copied without application");
endmodule // cir_top_sva
bind cir_top cir_top_sva i_sva (.*);

/* dv/tb_top.sv */
// Testbench: corner and random reset passes plus background checking
`timescale 1ns/1ps
module tb_top import cir_pkg::*;;
	logic sys_clk = 0, rstn = 0, rst_start = 0, sys_offchip = 0;
	logic alloc_fail = 0, map_fail = 0, comm_mismatch = 0;
	logic cfg_sizes_match = 1, mem_rvalid = 0, copy_done = 0;
	logic mem_rd, copy_req, copy_app, copy_cfg, copy_comm, copy_vars;
	logic state_we, log_we, reset_req, busy;
	logic [15:0] boot_options = 0;
	logic [1:0] dev_state_in = 0, state_out, got_st;
	logic [7:0] mem_rdata = 0, cfg_cks = 0, app_cks = 0, sys_cks = 0;
	logic [7:0] log_code, mem_addr, got_log, seen;
	logic [7:0] base [3] = '{8'h00, 8'h40, 8'h80};
	logic [7:0] len [3] = '{8'h01, 8'h01, 8'h01};
	logic [7:0] mem [256];
	logic [3:0] got_cp;
	logic [31:0] seed = 32'h32752889;
	int err_count = 0, comparisons = 0, cyc = 0;
	// Short background gap keeps the run brief
	cir_top #(.ADDR_W(8), .BG_GAP(4)) i_dut (.cfg_base(base[0]),
		.cfg_len(len[0]), .app_base(base[1]), .app_len(len[1]),
		.sys_base(base[2]), .sys_len(len[2]), .*);
	always #2 sys_clk = ~sys_clk;
	// Memory answers one cycle later; copies finish one cycle later; outputs logged
	always @(posedge sys_clk) begin
		#1;
		cyc++;
		mem_rvalid = mem_rd;
		mem_rdata = mem[mem_addr];
		copy_done = copy_req & !copy_done;
		if (copy_req) got_cp |= {copy_app, copy_cfg, copy_comm, copy_vars};
		if (log_we) got_log = log_code;
		if (state_we) got_st = state_out;
		if (cyc > 20000) begin
			err_count++;
			conclude();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Stored byte makes the area sum wrap to zero
	function automatic logic [7:0] cks(int a);
		logic [7:0] s = 8'h00;
		for (int i = 0; i < len[a]; i++) s += mem[base[a] + i];
		return -s;
	endfunction
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic check(string n, logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, exp, got);
		end
	endtask
	// One reset pass with chosen faults, then compare the outcome
	task automatic run_pass(logic [15:0] o, logic cb, ab, sb, logic [1:0] d);
		logic fat, ea, ec, em, sc;
		logic [1:0] es;
		logic [7:0] el;
		logic [31:0] r = rnd();
		for (int a = 0; a < 3; a++) begin
			base[a] = 8'(a * 64 + r[a*4+:4]);
			len[a] = 8'(1 + rnd() % 12);
		end
		for (int i = 0; i < 256; i++) mem[i] = 8'(rnd());
		cfg_cks = cks(0) ^ (cb ? 8'h5A : 8'h00);
		app_cks = cks(1) ^ (ab ? 8'hA5 : 8'h00);
		sys_cks = cks(2) ^ (sb ? 8'h3C : 8'h00);
		{sys_offchip, comm_mismatch, cfg_sizes_match} = r[14:12];
		alloc_fail = o[0] & r[15];
		map_fail = o[0] & r[16];
		boot_options = o;
		dev_state_in = d;
		{got_cp, got_log, got_st} = 0;
		rst_start = 1;
		tick();
		rst_start = 0;
		for (int n = 0; n < 3000 && busy !== 1'b0; n++) tick();
		repeat (12) tick();
		fat = ab | alloc_fail | map_fail | (o[9] & d == CIR_DEV_NOAPP);
		ea = (o[0] & fat) | o[1];
		ec = ((o[2] & cb) | (o[3] & fat) | o[4]) & (cfg_sizes_match | ea);
		em = (o[5] & cb) | (o[6] & comm_mismatch) | o[7];
		sc = sb & (sys_offchip | o[10]);
		check("copies", {4'h0, got_cp}, {4'h0, ea, ec, em, o[8] & ea});
		es = d;
		el = 8'h00;
		if (cb) el = CIR_ERR_CFG_CKS;
		if (cb & !(ec | o[5]) & d != CIR_DEV_NOAPP)
			es = CIR_DEV_UNCONFIGURED;
		// A reloaded application lifts applicationless state
		if (d == CIR_DEV_NOAPP & ea)
			es = ec ? CIR_DEV_CONFIGURED : CIR_DEV_UNCONFIGURED;
		if (ab) el = CIR_ERR_APP_CKS;
		if (ab & !ea) es = CIR_DEV_NOAPP;
		if (sc) el = CIR_ERR_SYS_CKS;
		if (sc) es = CIR_DEV_NOAPP;
		if (ea | ec | em) el = CIR_ERR_RECOVERY;
		check("state", {6'h0, got_st}, {6'h0, es});
		if ((o & 16'h0092) == 0) check("log", got_log, el);
		$display("pass done options %h", o);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rstn = 1;
		tick();
		run_pass(16'h0000, 1, 0, 0, 0);
		run_pass(16'h0000, 1, 1, 0, 1);
		run_pass(16'h0400, 0, 0, 1, 0);
		run_pass(16'h0024, 1, 0, 0, 0);
		run_pass(16'h0020, 1, 0, 0, 1);
		run_pass(16'h0109, 0, 1, 0, 0);
		run_pass(16'h00D2, 0, 0, 0, 0);
		run_pass(16'h0201, 0, 0, 0, 2);
		for (int k = 0; k < 40; k++) begin
			seen = 8'(rnd());
			run_pass(16'(rnd()) & 16'h036D, seen[0], seen[1], seen[2],
				{1'b0, seen[3]});
		end
		run_pass(16'h0000, 0, 0, 0, 0);
		app_cks ^= 8'h01;
		for (int n = 0; n < 2000 && reset_req !== 1'b1; n++) tick();
		check("bg reset", {7'h0, reset_req}, 8'h01);
		run_pass(16'h0000, 0, 1, 0, 0);
		seen = 0;
		repeat (500) begin
			tick();
			seen |= {7'h0, mem_rd | reset_req};
		end
		check("noapp quiet", seen, 8'h00);
		$display("background tests done");
		conclude();
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
endmodule // tb_top
